// ---- efs_dev_end.sv ----
// Device end: sinks transmit channels, sources receive data and status.
`timescale 1ns/1ps
`include "efs_consts.svh"
module efs_dev_end
  import efs_pkg::*;
#(
  parameter int STAT_WORDS = `EFS_STAT_WORDS
) (
  input  wire logic      mclk,
  input  wire logic      srst,
  efs_if.dev             port,
  output logic           tx_frame_valid,
  input  wire logic      tx_space,
  output efs_word_t      tx_frame_data,
  output efs_keep_t      tx_frame_keep,
  output logic           tx_frame_last,
  output logic           tx_frame_rxstat,
  output efs_word_t      tx_ctrl_word,
  output logic [2:0]     tx_ctrl_index,
  output logic           tx_ctrl_strobe,
  input  wire logic      rx_valid,
  input  wire efs_word_t rx_data,
  input  wire efs_keep_t rx_keep,
  input  wire logic      rx_last,
  input  wire logic      rx_buf_full,
  output logic           rx_dropped
);
  function automatic logic [3:0] flag_of(input efs_word_t w);
    return w[`EFS_FLAG_MSB:`EFS_FLAG_LSB];
  endfunction

  efs_tx_state_t tx_state_reg;
  logic [2:0]    cw_idx_reg;
  logic          rxstat_reg;
  logic          txc_take;
  logic          txd_take;

  // R11 - Data blocked until control done.
  // R16 - Full buffer holds off data.
  assign port.txd_tready = (tx_state_reg == EFS_TX_DATA) && tx_space;
  // R12 - Control blocked during data.
  assign port.txc_tready = (tx_state_reg != EFS_TX_DATA);
  assign txc_take        = port.txc_tvalid && port.txc_tready;
  assign txd_take        = port.txd_tvalid && port.txd_tready;

  // R18 - Pair control with frame.
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_state_reg <= EFS_TX_CTRL;
      cw_idx_reg   <= 3'h0;
      rxstat_reg   <= 1'b0;
    end else begin
      case (tx_state_reg)
        EFS_TX_CTRL: begin
          if (txc_take) begin
            cw_idx_reg <= cw_idx_reg + 3'h1;
            // R8 - Flag nibble selects type.
            if (cw_idx_reg == 3'h0) begin
              rxstat_reg <= (flag_of(port.txc_tdata) == `EFS_FLAG_RXSTAT);
              if (flag_of(port.txc_tdata) != `EFS_FLAG_NORMAL &&
                  flag_of(port.txc_tdata) != `EFS_FLAG_RXSTAT) begin
                tx_state_reg <= port.txc_tlast ? EFS_TX_CTRL : EFS_TX_SKIP;
                cw_idx_reg   <= port.txc_tlast ? 3'h0 : 3'h1;
              end
            end
            // R10 - Packet ends on tlast.
            if (port.txc_tlast) begin
              cw_idx_reg <= 3'h0;
              if (cw_idx_reg != 3'h0 ||
                  flag_of(port.txc_tdata) == `EFS_FLAG_NORMAL ||
                  flag_of(port.txc_tdata) == `EFS_FLAG_RXSTAT) begin
                tx_state_reg <= EFS_TX_DATA;
              end
            end
          end
        end
        EFS_TX_SKIP: begin
          if (txc_take && port.txc_tlast) begin
            tx_state_reg <= EFS_TX_CTRL;
            cw_idx_reg   <= 3'h0;
          end
        end
        EFS_TX_DATA: begin
          // R1 - Frame ends on tlast.
          if (txd_take && port.txd_tlast) begin
            tx_state_reg <= EFS_TX_CTRL;
          end
        end
        default: tx_state_reg <= EFS_TX_CTRL;
      endcase
    end
  end

  // R14 - Keep carried, never decoded.
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_frame_valid  <= 1'b0;
      tx_frame_data   <= 32'h0000_0000;
      tx_frame_keep   <= 4'h0;
      tx_frame_last   <= 1'b0;
      tx_frame_rxstat <= 1'b0;
    end else begin
      tx_frame_valid <= txd_take;
      if (txd_take) begin
        tx_frame_data   <= port.txd_tdata;
        tx_frame_keep   <= port.txd_tkeep;
        tx_frame_last   <= port.txd_tlast;
        tx_frame_rxstat <= rxstat_reg;
      end
    end
  end

  // Control words are exposed one per accepted beat of a valid packet, plus the first word of an ignored one.
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_ctrl_strobe <= 1'b0;
      tx_ctrl_word   <= 32'h0000_0000;
      tx_ctrl_index  <= 3'h0;
    end else begin
      tx_ctrl_strobe <= txc_take && (tx_state_reg == EFS_TX_CTRL);
      if (txc_take) begin
        tx_ctrl_word  <= port.txc_tdata;
        tx_ctrl_index <= cw_idx_reg;
      end
    end
  end

  // Receive side.
  efs_rx_state_t rx_state_reg;
  logic [2:0]    st_cnt_reg;
  logic [15:0]   rx_len_reg;
  logic          rxd_hold;

  // R6 - Hold word while not ready.
  assign rxd_hold = port.rxd_tvalid && !port.rxd_tready;

  // R17 - Drop frames when full.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_state_reg <= EFS_RX_IDLE;
      rx_dropped   <= 1'b0;
      st_cnt_reg   <= 3'h0;
    end else begin
      rx_dropped <= 1'b0;
      case (rx_state_reg)
        EFS_RX_IDLE: begin
          if (rx_valid && !rxd_hold) begin
            if (rx_buf_full) begin
              rx_state_reg <= rx_last ? EFS_RX_IDLE : EFS_RX_DROP;
              rx_dropped   <= rx_last;
            end else begin
              rx_state_reg <= rx_last ? EFS_RX_STAT : EFS_RX_DATA;
            end
          end
        end
        EFS_RX_DATA: begin
          if (rx_valid && !rxd_hold && rx_last) begin
            rx_state_reg <= EFS_RX_STAT;
          end
        end
        EFS_RX_DROP: begin
          if (rx_valid && rx_last) begin
            rx_state_reg <= EFS_RX_IDLE;
            rx_dropped   <= 1'b1;
          end
        end
        EFS_RX_STAT: begin
          if (!port.rxd_tvalid && port.rxs_tvalid && port.rxs_tready) begin
            st_cnt_reg <= st_cnt_reg + 3'h1;
            if (port.rxs_tlast) begin
              st_cnt_reg   <= 3'h0;
              rx_state_reg <= EFS_RX_IDLE;
            end
          end
        end
        default: rx_state_reg <= EFS_RX_IDLE;
      endcase
    end
  end

  // R3 - Upstream keeps full words mid-frame.
  // R4 - Last word keep passed through.
  always_ff @(posedge mclk) begin
    if (srst) begin
      port.rxd_tvalid <= 1'b0;
      port.rxd_tdata  <= 32'h0000_0000;
      port.rxd_tkeep  <= 4'h0;
      port.rxd_tlast  <= 1'b0;
      rx_len_reg      <= 16'h0000;
    end else if (!rxd_hold) begin
      port.rxd_tvalid <= rx_valid && (rx_state_reg == EFS_RX_DATA ||
                         (rx_state_reg == EFS_RX_IDLE && !rx_buf_full));
      port.rxd_tdata  <= rx_data;
      port.rxd_tkeep  <= rx_keep;
      port.rxd_tlast  <= rx_last;
      if (rx_valid && rx_state_reg == EFS_RX_IDLE) begin
        rx_len_reg <= 16'h0001;
      end else if (rx_valid && rx_state_reg == EFS_RX_DATA) begin
        rx_len_reg <= rx_len_reg + 16'h0001;
      end
    end
  end

  // R9 - One status format only.
  // R13 - Status keep all ones.
  assign port.rxs_tvalid = (rx_state_reg == EFS_RX_STAT) && !port.rxd_tvalid;
  assign port.rxs_tkeep  = `EFS_KEEP_ALL;
  assign port.rxs_tlast  = (st_cnt_reg == 3'(STAT_WORDS - 1));
  assign port.rxs_tdata  = (st_cnt_reg == 3'h0) ?
                           {`EFS_STAT_FLAG, 28'h000_0000} : {16'h0000, rx_len_reg};
endmodule // efs_dev_end

// ---- efs_consts.svh ----
// Constants for the frame stream port, with the contract list.
// Contract
// R1 - Packets of 32-bit words, tlast on final word
// R2 - One tkeep bit per byte, set is valid
// R3 - All words before last carry four bytes
// R4 - Last word packs 1 to 4 bytes low
// R5 - Source pauses by dropping tvalid
// R6 - Destination pauses by dropping tready
// R7 - Tx data plus control, rx data plus status
// R8 - Control first nibble 0xA or 0x5, else ignored
// R9 - Status channel uses one packet format only
// R10 - Control packet is six words per frame
// R11 - Data tready low until control packet accepted
// R12 - Control tready low until data packet ends
// R13 - Control and status tkeep always all ones
// R14 - Data tkeep patterns are constants, unused logic
// R15 - System sources transmit, device sources receive
// R16 - Full transmit buffer holds data tready low
// R17 - Full receive buffer discards incoming frames
// R18 - One control packet per frame, same order
`ifndef EFS_CONSTS_SVH
`define EFS_CONSTS_SVH
`define EFS_DATA_W       32
`define EFS_KEEP_W       4
`define EFS_KEEP_ALL     4'hF
`define EFS_CTRL_WORDS   6
`define EFS_FLAG_MSB     31
`define EFS_FLAG_LSB     28
`define EFS_FLAG_NORMAL  4'hA
`define EFS_FLAG_RXSTAT  4'h5
`define EFS_STAT_FLAG    4'h5
`define EFS_STAT_WORDS   6
`endif

// ---- efs_pkg.sv ----
// Types shared by both ends of the frame stream port.
package efs_pkg;
  typedef enum logic [1:0] {
    EFS_TX_CTRL,
    EFS_TX_DATA,
    EFS_TX_SKIP
  } efs_tx_state_t;
  typedef enum logic [1:0] {
    EFS_RX_IDLE,
    EFS_RX_DATA,
    EFS_RX_DROP,
    EFS_RX_STAT
  } efs_rx_state_t;
  typedef logic [31:0] efs_word_t;
  typedef logic [3:0]  efs_keep_t;
endpackage

// ---- efs_if.sv ----
// Interface carrying the four stream channels between system and device.
`timescale 1ns/1ps
interface efs_if;
  // R7 - Paired channels, one clock.
  logic [31:0] txd_tdata;
  logic [3:0]  txd_tkeep;
  logic        txd_tlast;
  logic        txd_tvalid;
  logic        txd_tready;
  logic [31:0] txc_tdata;
  logic [3:0]  txc_tkeep;
  logic        txc_tlast;
  logic        txc_tvalid;
  logic        txc_tready;
  logic [31:0] rxd_tdata;
  logic [3:0]  rxd_tkeep;
  logic        rxd_tlast;
  logic        rxd_tvalid;
  logic        rxd_tready;
  logic [31:0] rxs_tdata;
  logic [3:0]  rxs_tkeep;
  logic        rxs_tlast;
  logic        rxs_tvalid;
  logic        rxs_tready;
  modport dev (
    input  txd_tdata, txd_tkeep, txd_tlast, txd_tvalid,
    output txd_tready,
    input  txc_tdata, txc_tkeep, txc_tlast, txc_tvalid,
    output txc_tready,
    output rxd_tdata, rxd_tkeep, rxd_tlast, rxd_tvalid,
    input  rxd_tready,
    output rxs_tdata, rxs_tkeep, rxs_tlast, rxs_tvalid,
    input  rxs_tready
  );
  modport sys (
    output txd_tdata, txd_tkeep, txd_tlast, txd_tvalid,
    input  txd_tready,
    output txc_tdata, txc_tkeep, txc_tlast, txc_tvalid,
    input  txc_tready,
    input  rxd_tdata, rxd_tkeep, rxd_tlast, rxd_tvalid,
    output rxd_tready,
    input  rxs_tdata, rxs_tkeep, rxs_tlast, rxs_tvalid,
    output rxs_tready
  );
endinterface // efs_if

// ---- efs_src_reg.sv ----
// Registered stream source stage used by the system end.
`timescale 1ns/1ps
module efs_src_reg
  import efs_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      srst,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire efs_word_t in_data,
  input  wire efs_keep_t in_keep,
  input  wire logic      in_last,
  output logic           out_valid,
  input  wire logic      out_ready,
  output efs_word_t      out_data,
  output efs_keep_t      out_keep,
  output logic           out_last
);
  // R5 - Valid held while paused.
  assign in_ready = !out_valid || out_ready;
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_valid <= 1'b0;
    end else if (in_ready) begin
      out_valid <= in_valid;
    end
  end
  // R6 - Word held until ready.
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_data <= 32'h0000_0000;
      out_keep <= 4'h0;
      out_last <= 1'b0;
    end else if (in_ready && in_valid) begin
      out_data <= in_data;
      out_keep <= in_keep;
      out_last <= in_last;
    end
  end
endmodule // efs_src_reg

// ---- efs_sys_end.sv ----
// System end: sources transmit data and control, sinks receive data and status.
`timescale 1ns/1ps
`include "efs_consts.svh"
module efs_sys_end
  import efs_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      srst,
  efs_if.sys             port,
  input  wire logic      ctl_valid,
  output logic           ctl_ready,
  input  wire efs_word_t ctl_data,
  input  wire logic      ctl_last,
  input  wire logic      dat_valid,
  output logic           dat_ready,
  input  wire efs_word_t dat_data,
  input  wire efs_keep_t dat_keep,
  input  wire logic      dat_last,
  output logic           rxd_valid,
  input  wire logic      rxd_ready,
  output efs_word_t      rxd_data,
  output efs_keep_t      rxd_keep,
  output logic           rxd_last,
  output logic           rxs_valid,
  input  wire logic      rxs_ready,
  output efs_word_t      rxs_data,
  output logic           rxs_last
);
  // R15 - System sources the transmit channels.
  efs_src_reg u_ctl (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (ctl_valid),
    .in_ready  (ctl_ready),
    .in_data   (ctl_data),
    // R13 - Control keep all ones.
    .in_keep   (`EFS_KEEP_ALL),
    .in_last   (ctl_last),
    .out_valid (port.txc_tvalid),
    .out_ready (port.txc_tready),
    .out_data  (port.txc_tdata),
    .out_keep  (port.txc_tkeep),
    .out_last  (port.txc_tlast)
  );
  // R2 - Keep passed per byte.
  efs_src_reg u_dat (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (dat_valid),
    .in_ready  (dat_ready),
    .in_data   (dat_data),
    .in_keep   (dat_keep),
    .in_last   (dat_last),
    .out_valid (port.txd_tvalid),
    .out_ready (port.txd_tready),
    .out_data  (port.txd_tdata),
    .out_keep  (port.txd_tkeep),
    .out_last  (port.txd_tlast)
  );
  // R6 - Sink pauses via ready.
  assign port.rxd_tready = rxd_ready;
  assign port.rxs_tready = rxs_ready;
  assign rxd_valid       = port.rxd_tvalid;
  assign rxd_data        = port.rxd_tdata;
  assign rxd_keep        = port.rxd_tkeep;
  assign rxd_last        = port.rxd_tlast;
  assign rxs_valid       = port.rxs_tvalid;
  assign rxs_data        = port.rxs_tdata;
  assign rxs_last        = port.rxs_tlast;
endmodule // efs_sys_end

// ---- efs_port_asserts.sv ----
// Concurrent checks on the four stream channels between the two ends.
`timescale 1ns/1ps
module efs_port_asserts #(
  parameter int STAT_WORDS = 6
) (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [31:0] txd_tdata,
  input wire logic        txd_tlast,
  input wire logic        txd_tvalid,
  input wire logic        txd_tready,
  input wire logic [3:0]  txc_tkeep,
  input wire logic        txc_tlast,
  input wire logic        txc_tvalid,
  input wire logic        txc_tready,
  input wire logic [31:0] rxd_tdata,
  input wire logic [3:0]  rxd_tkeep,
  input wire logic        rxd_tlast,
  input wire logic        rxd_tvalid,
  input wire logic        rxd_tready,
  input wire logic [31:0] rxs_tdata,
  input wire logic [3:0]  rxs_tkeep,
  input wire logic        rxs_tlast,
  input wire logic        rxs_tvalid,
  input wire logic        rxs_tready
);
  logic       armed_reg;
  logic [2:0] scnt_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // Armed only after a whole control packet, so a partial one never opens data.
  always_ff @(posedge mclk) begin
    if (srst) armed_reg <= 1'h0;
    else if (txc_tvalid && txc_tready) armed_reg <= txc_tlast;
    else if (txd_tvalid && txd_tready && txd_tlast) armed_reg <= 1'h0;
  end
  always_ff @(posedge mclk) begin
    if (srst) scnt_reg <= 3'h0;
    else if (rxs_tvalid && rxs_tready) scnt_reg <= rxs_tlast ? 3'h0 : scnt_reg + 3'h1;
  end
  chk_data_gated: assert property (txd_tready |-> armed_reg)
    else $error("data ready before control packet");
  chk_ctrl_held: assert property (txd_tready |-> !txc_tready)
    else $error("control ready during data packet");
  chk_ctrl_keep: assert property (txc_tvalid |-> txc_tkeep == 4'hF)
    else $error("control keep not all ones");
  chk_stat_keep: assert property (rxs_tvalid |-> rxs_tkeep == 4'hF)
    else $error("status keep not all ones");
  chk_txd_pause: assert property (txd_tvalid && !txd_tready |=>
    txd_tvalid && $stable(txd_tdata) && $stable(txd_tlast))
    else $error("transmit word changed while stalled");
  chk_rxd_pause: assert property (rxd_tvalid && !rxd_tready |=>
    rxd_tvalid && $stable(rxd_tdata) && $stable(rxd_tlast))
    else $error("receive word changed while stalled");
  chk_rxs_pause: assert property (rxs_tvalid && !rxs_tready |=>
    rxs_tvalid && $stable(rxs_tdata) && $stable(rxs_tlast))
    else $error("status word changed while stalled");
  chk_rxd_full: assert property (rxd_tvalid && !rxd_tlast |-> rxd_tkeep == 4'hF)
    else $error("sparse word before last");
  chk_rxd_packed: assert property (rxd_tvalid && rxd_tlast |->
    rxd_tkeep inside {4'h1, 4'h3, 4'h7, 4'hF})
    else $error("last word keep not packed low");
  chk_stat_len: assert property (rxs_tvalid && rxs_tlast |-> scnt_reg == 3'(STAT_WORDS - 1))
    else $error("status packet length wrong");
  chk_stat_flag: assert property (rxs_tvalid && scnt_reg == 3'h0 |->
    rxs_tdata[31:28] == 4'h5)
    else $error("status first word flag wrong");
endmodule // efs_port_asserts

// ---- tb.sv ----
// Self-checking bench joining the system and device ends of the frame stream port.
`timescale 1ns/1ps
module tb
  import efs_pkg::*;
;
  localparam int SW = 6;
  logic        mclk = 1'h0, srst = 1'h1, tx_space = 1'h1, rxd_ready = 1'h1, rxs_ready = 1'h1;
  logic        ctl_valid = 1'h0, ctl_last = 1'h0, dat_valid = 1'h0, dat_last = 1'h0;
  logic        rx_valid = 1'h0, rx_last = 1'h0, rx_buf_full = 1'h0;
  efs_word_t   ctl_data = '0, dat_data = '0, rx_data = '0;
  efs_keep_t   dat_keep = 4'hF, rx_keep = 4'hF;
  logic        ctl_ready, dat_ready, rxd_valid, rxd_last, rxs_valid, rxs_last, rx_dropped;
  logic        tx_frame_valid, tx_frame_last, tx_frame_rxstat, tx_ctrl_strobe;
  efs_word_t   rxd_data, rxs_data, tx_frame_data, tx_ctrl_word;
  efs_keep_t   rxd_keep, tx_frame_keep;
  logic [2:0]  tx_ctrl_index;
  int          error_cnt = 0, n_compared = 0, nstat = 0, ndrop = 0, sidx = 0, rx_words = 0;
  logic [31:0] seed = 32'h0000_f050, pace = 32'h0000_f050;
  logic [37:0] tq[$], rq[$], t;
  logic [34:0] cq[$], c;
  efs_if bus ();
  efs_sys_end i_efs_sys_end (
    .mclk, .srst, .port(bus), .ctl_valid, .ctl_ready, .ctl_data, .ctl_last,
    .dat_valid, .dat_ready, .dat_data, .dat_keep, .dat_last, .rxd_valid, .rxd_ready,
    .rxd_data, .rxd_keep, .rxd_last, .rxs_valid, .rxs_ready, .rxs_data, .rxs_last);
  efs_dev_end #(.STAT_WORDS(SW)) i_efs_dev_end (
    .mclk, .srst, .port(bus), .tx_frame_valid, .tx_space, .tx_frame_data, .tx_frame_keep,
    .tx_frame_last, .tx_frame_rxstat, .tx_ctrl_word, .tx_ctrl_index, .tx_ctrl_strobe,
    .rx_valid, .rx_data, .rx_keep, .rx_last, .rx_buf_full, .rx_dropped);
  efs_port_asserts #(.STAT_WORDS(SW)) i_efs_port_asserts (
    .mclk, .srst, .txd_tdata(bus.txd_tdata), .txd_tlast(bus.txd_tlast),
    .txd_tvalid(bus.txd_tvalid), .txd_tready(bus.txd_tready), .txc_tkeep(bus.txc_tkeep),
    .txc_tlast(bus.txc_tlast), .txc_tvalid(bus.txc_tvalid), .txc_tready(bus.txc_tready),
    .rxd_tdata(bus.rxd_tdata), .rxd_tkeep(bus.rxd_tkeep), .rxd_tlast(bus.rxd_tlast),
    .rxd_tvalid(bus.rxd_tvalid), .rxd_tready(bus.rxd_tready), .rxs_tdata(bus.rxs_tdata),
    .rxs_tkeep(bus.rxs_tkeep), .rxs_tlast(bus.rxs_tlast), .rxs_tvalid(bus.rxs_tvalid),
    .rxs_tready(bus.rxs_tready));
  always #20 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Last word holds 4, 3, 2 or 1 bytes packed low.
  function automatic efs_keep_t last_keep(input logic [1:0] n);
    return 4'hF >> n;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ready is sampled at the falling edge, where the combinational path has settled.
  task automatic await(input bit dat);
    int   k;
    logic r;
    k = 0;
    do begin
      @(negedge mclk);
      r = dat ? dat_ready : ctl_ready;
      @(posedge mclk);
      k++;
    end while (r !== 1'h1 && k < 2000);
    if (r !== 1'h1) check("ready wait", 1, r);
    #1;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Random stalls on transmit data, receive data and status readies so both pause directions get exercised.
  always @(posedge mclk) begin
    #1;
    pace = lfsr(pace);
    tx_space = pace[0] | pace[1];
    rxd_ready = pace[2] | pace[3];
    rxs_ready = pace[4] | pace[5];
  end
  always @(negedge mclk) if (srst === 1'h0) begin
    if (tx_ctrl_strobe === 1'h1) begin
      c = cq.pop_front();
      check("ctrl word", c[31:0], tx_ctrl_word);
      check("ctrl index", c[34:32], tx_ctrl_index);
    end
    if (tx_frame_valid === 1'h1) begin
      t = tq.pop_front();
      check("frame data", t[31:0], tx_frame_data);
      check("frame keep", t[35:32], tx_frame_keep);
      check("frame last", t[36], tx_frame_last);
      check("frame kind", t[37], tx_frame_rxstat);
    end
    if (rxd_valid === 1'h1 && rxd_ready === 1'h1) begin
      t = rq.pop_front();
      check("rx data", t[31:0], rxd_data);
      check("rx keep", t[35:32], rxd_keep);
      check("rx last", t[36], rxd_last);
    end
    if (rxs_valid === 1'h1 && rxs_ready === 1'h1) begin
      if (sidx == 0) check("stat flag", 4'h5, rxs_data[31:28]);
      else check("stat count", rx_words, rxs_data);
      check("stat last", sidx == SW - 1, rxs_last);
      sidx = (rxs_last === 1'h1) ? 0 : sidx + 1;
      nstat++;
    end
    if (rx_dropped === 1'h1) ndrop++;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    complete_run();
  end
  initial begin
    logic [3:0] flags [6];
    int         n, k;
    flags = '{4'hA, 4'h5, 4'h3, 4'hA, 4'h0, 4'h5};
    repeat (5) @(posedge mclk);
    #1 srst = 1'h0;
    for (int f = 0; f < 6; f++) begin
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        ctl_data = (i == 0) ? {flags[f], seed[27:0]} : seed;
        ctl_last = (i == 5);
        if (i == 0 || flags[f] == 4'hA || flags[f] == 4'h5) cq.push_back({3'(i), ctl_data});
        ctl_valid = 1'h1;
        await(1'h0);
      end
      ctl_valid = 1'h0;
      if (flags[f] == 4'hA || flags[f] == 4'h5) begin
        n = (f == 0) ? 1 : int'(seed[2:0]) + 2;
        for (int i = 0; i < n; i++) begin
          seed = lfsr(seed);
          dat_data = seed;
          dat_last = (i == n - 1);
          dat_keep = dat_last ? last_keep(seed[5:4]) : 4'hF;
          tq.push_back({flags[f] == 4'h5, dat_last, dat_keep, dat_data});
          dat_valid = 1'h1;
          await(1'h1);
        end
        dat_valid = 1'h0;
      end
    end
    repeat (30) @(posedge mclk);
    check("tx left", 0, tq.size() + cq.size());
    $display("tx test done");
    #1;
    for (int f = 0; f < 4; f++) begin
      n = (f == 0) ? 1 : int'(seed[2:0]) + 2;
      rx_buf_full = (f == 3);
      rx_words = n;
      for (int i = 0; i < n; i++) begin
        seed = lfsr(seed);
        rx_data = seed;
        rx_last = (i == n - 1);
        rx_keep = rx_last ? last_keep(seed[9:8]) : 4'hF;
        if (f < 3) rq.push_back({1'h0, rx_last, rx_keep, rx_data});
        rx_valid = 1'h1;
        @(posedge mclk);
        #1 rx_valid = 1'h0;
        k = 0;
        do begin
          @(posedge mclk);
          k++;
        end while (rq.size() > 0 && k < 500);
        #1;
      end
      repeat (30) @(posedge mclk);
      #1;
    end
    check("stat beats", 3 * SW, nstat);
    check("drops", 1, ndrop);
    check("rx left", 0, rq.size());
    $display("rx test done");
    complete_run();
  end
endmodule // tb
